// >>> rtl/sbp_serial_buffer.sv
// serial receive/transmit buffers with flow control and packet release
`timescale 1ns/100ps
`default_nettype none

// fifo with registered output stage; depth must be a power of two
module sbp_fifo #(
  parameter int W     = 9,
  parameter int DEPTH = sbp_pkg::FIFO_DEPTH_DEF,
  parameter int CW    = $clog2(DEPTH + 1)
) (
  input  wire logic          clk_in,       // system clock
  input  wire logic          resetn_in,    // async reset, active low
  input  wire logic          in_valid_in,  // write request
  input  wire logic [W-1:0]  in_data_in,   // write data
  output logic               in_ready_out, // room for one more word
  output logic               out_valid_out,// head word present
  output logic [W-1:0]       out_data_out, // head word
  input  wire logic          out_ready_in, // head word taken
  output logic [CW-1:0]      free_out      // free words
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wp, rp, next_wp, next_rp;
  logic [CW-1:0] mem_cnt, next_mem_cnt, next_total, next_free;
  logic          wr, pop, ld, next_ov, next_ready;
  logic [W-1:0]  next_od;

  always_comb begin
    wr           = in_valid_in & in_ready_out;
    pop          = out_valid_out & out_ready_in;
    ld           = (mem_cnt != '0) & (~out_valid_out | pop);
    next_wp      = wp + AW'(wr);
    next_rp      = rp + AW'(ld);
    next_mem_cnt = mem_cnt + CW'(wr) - CW'(ld);
    next_ov      = ld | (out_valid_out & ~pop);
    next_od      = ld ? mem[rp] : out_data_out;
    next_total   = next_mem_cnt + CW'(next_ov);
    // ready and free look one write ahead so they can be registered
    next_ready   = next_total < CW'(DEPTH);
    next_free    = CW'(DEPTH) - next_total;
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wp            <= '0;
      rp            <= '0;
      mem_cnt       <= '0;
      out_valid_out <= 1'b0;
      out_data_out  <= '0;
      in_ready_out  <= 1'b1;
      free_out      <= CW'(DEPTH);
    end else begin
      wp            <= next_wp;
      rp            <= next_rp;
      mem_cnt       <= next_mem_cnt;
      out_valid_out <= next_ov;
      out_data_out  <= next_od;
      in_ready_out  <= next_ready;
      free_out      <= next_free;
    end
  end

  always_ff @(posedge clk_in) begin
    if (wr) begin
      mem[wp] <= in_data_in;
    end
  end
endmodule

module sbp_serial_buffer #(
  parameter int RX_DEPTH = sbp_pkg::RX_DEPTH_DEF,
  parameter int TX_DEPTH = sbp_pkg::TX_DEPTH_DEF,
  parameter int PKT_MAX  = sbp_pkg::PKT_MAX_DEF,
  parameter int RXW      = $clog2(RX_DEPTH + 1),
  parameter int TXW      = $clog2(TX_DEPTH + 1)
) (
  input  wire logic           clk_in,                   // 50 mhz clock
  input  wire logic           resetn_in,                // async, low
  input  wire logic           rts_flow_enable_setting_in, // rts gate on
  input  wire logic           cts_flow_enable_setting_in, // cts out on
  input  wire logic           framed_mode_in,           // 1 framed
  input  wire logic           command_mode_in,          // cmd mode on
  input  wire logic [7:0]     packetization_timeout_in, // char times
  input  wire logic           char_tick_in,             // one char time
  input  wire logic           cmd_seq_detect_in,        // sequence seen
  input  wire logic           ser_rx_valid_in,          // byte from uart
  input  wire logic [7:0]     ser_rx_data_in,           // byte value
  input  wire logic           ser_rx_last_in,           // frame end
  output logic                ser_rx_ready_out,         // buffer room
  output logic                cts_n_out,                // cts, low = go
  output logic [RXW-1:0]      rx_free_out,              // rx free bytes
  input  wire logic           rf_rx_busy_in,            // rf rx running
  output logic                pkt_valid_out,            // packet byte
  output logic [7:0]          pkt_data_out,             // byte value
  output logic                pkt_last_out,             // packet end
  input  wire logic           pkt_ready_in,             // packetizer take
  input  wire logic           rf_rx_valid_in,           // rf payload byte
  input  wire logic [7:0]     rf_rx_data_in,            // byte value
  input  wire logic           rf_rx_first_in,           // first byte
  input  wire logic           rf_rx_last_in,            // last byte
  input  wire logic [7:0]     rf_rx_len_in,             // payload length
  input  wire logic [15:0]    rf_rx_src_in,             // sender address
  output logic                rf_rx_ready_out,          // byte taken
  input  wire logic           evt_valid_in,             // frame byte in
  input  wire logic [7:0]     evt_data_in,              // frame byte
  output logic                evt_ready_out,            // frame byte taken
  output logic                ser_tx_valid_out,         // byte to uart
  output logic [7:0]          ser_tx_data_out,          // byte value
  input  wire logic           ser_tx_ready_in,          // uart took byte
  input  wire logic           rts_n_in,                 // rts, high = stop
  output logic [TXW-1:0]      tx_free_out               // tx free bytes
);
  sbp_pkg::sbp_byte_s rx_in, rx_out;
  sbp_pkg::sbp_pk_e   pst, next_pst;
  sbp_pkg::sbp_in_e   ist, next_ist;
  localparam int FW = sbp_pkg::FIT_W;
  logic           rx_out_valid, rx_pop, rx_wr, pkt_take, flush_pend;
  logic           next_flush, next_pkt_valid, next_pkt_last, next_cts_n;
  logic [7:0]     next_pkt_data, idle_cnt, next_idle;
  logic [RXW-1:0] rx_used, rel_left, next_rel, frm_cnt, next_frm;
  logic [7:0]     tx_wdata, next_tx_data, tx_out;
  logic           tx_wr, tx_in_ready, tx_out_valid, tx_pop, fits;
  logic           next_rf_ready, next_evt_ready, next_tx_valid, rts_hold;

  // rx buffer sits between the uart input and the packetizer
  sbp_fifo #(.W(9), .DEPTH(RX_DEPTH), .CW(RXW)) u_rx_buf (
    .clk_in        (clk_in),
    .resetn_in     (resetn_in),
    .in_valid_in   (ser_rx_valid_in),
    .in_data_in    (rx_in),
    .in_ready_out  (ser_rx_ready_out),
    .out_valid_out (rx_out_valid),
    .out_data_out  (rx_out),
    .out_ready_in  (rx_pop),
    .free_out      (rx_free_out)
  );

  sbp_fifo #(.W(8), .DEPTH(TX_DEPTH), .CW(TXW)) u_tx_buf (
    .clk_in        (clk_in),
    .resetn_in     (resetn_in),
    .in_valid_in   (tx_wr),
    .in_data_in    (tx_wdata),
    .in_ready_out  (tx_in_ready),
    .out_valid_out (tx_out_valid),
    .out_data_out  (tx_out),
    .out_ready_in  (tx_pop),
    .free_out      (tx_free_out)
  );

  // receive side: release sequencer, idle timer, cts
  always_comb begin
    rx_in.data     = ser_rx_data_in;
    rx_in.last     = ser_rx_last_in & framed_mode_in;
    rx_wr          = ser_rx_valid_in & ser_rx_ready_out;
    rx_used        = RXW'(RX_DEPTH) - rx_free_out;
    pkt_take       = ~pkt_valid_out | pkt_ready_in;
    // bytes stay put while rf reception runs
    rx_pop         = rx_out_valid & pkt_take & ~rf_rx_busy_in &
                     ((pst == sbp_pkg::P_SEND) | (pst == sbp_pkg::P_FRAME));
    next_pst       = pst;
    next_rel       = rel_left;
    next_flush     = flush_pend | cmd_seq_detect_in;
    next_frm       = frm_cnt + RXW'(rx_wr & rx_in.last)
                     - RXW'(rx_pop & rx_out.last);
    unique case (pst)
      sbp_pkg::P_IDLE: begin
        if (!rf_rx_busy_in && framed_mode_in && frm_cnt != '0) begin
          next_pst = sbp_pkg::P_FRAME;
        end else if (!rf_rx_busy_in && !framed_mode_in && rx_used != '0 &&
                     (flush_pend ||
                      (!command_mode_in &&
                       (rx_used >= RXW'(PKT_MAX) ||
                        idle_cnt >= packetization_timeout_in)))) begin
          next_pst   = sbp_pkg::P_SEND;
          next_rel   = (rx_used > RXW'(PKT_MAX)) ? RXW'(PKT_MAX) : rx_used;
          // a flush longer than one packet stays pending for the rest
          next_flush = cmd_seq_detect_in |
                       (flush_pend & (rx_used > RXW'(PKT_MAX)));
        end
      end
      sbp_pkg::P_SEND: begin
        if (rx_pop) begin
          next_rel = rel_left - RXW'(1);
          if (rel_left == RXW'(1)) begin
            next_pst = sbp_pkg::P_IDLE;
          end
        end
      end
      sbp_pkg::P_FRAME: begin
        if (rx_pop && rx_out.last) begin
          next_pst = sbp_pkg::P_IDLE;
        end
      end
    endcase
    next_pkt_valid = pkt_valid_out & ~pkt_ready_in;
    next_pkt_data  = pkt_data_out;
    next_pkt_last  = pkt_last_out;
    if (rx_pop) begin
      next_pkt_valid = 1'b1;
      next_pkt_data  = rx_out.data;
      next_pkt_last  = framed_mode_in ? rx_out.last : (rel_left == RXW'(1));
    end
    next_idle = idle_cnt;
    if (rx_wr) begin
      next_idle = sbp_pkg::IDLE_RST;
    end else if (char_tick_in && idle_cnt != 8'hff) begin
      next_idle = idle_cnt + 8'h01;
    end
    next_cts_n = cts_n_out;
    if (!cts_flow_enable_setting_in) begin
      next_cts_n = 1'b0;
    end else if (rx_free_out <= RXW'(sbp_pkg::CTS_OFF_FREE)) begin
      next_cts_n = 1'b1;
    end else if (rx_free_out >= RXW'(sbp_pkg::CTS_ON_FREE)) begin
      next_cts_n = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pst           <= sbp_pkg::P_IDLE;
      rel_left      <= '0;
      flush_pend    <= 1'b0;
      frm_cnt       <= '0;
      pkt_valid_out <= 1'b0;
      pkt_data_out  <= 8'h00;
      pkt_last_out  <= 1'b0;
      idle_cnt      <= sbp_pkg::IDLE_RST;
      cts_n_out     <= sbp_pkg::CTS_N_RST;
    end else begin
      pst           <= next_pst;
      rel_left      <= next_rel;
      flush_pend    <= next_flush;
      frm_cnt       <= next_frm;
      pkt_valid_out <= next_pkt_valid;
      pkt_data_out  <= next_pkt_data;
      pkt_last_out  <= next_pkt_last;
      idle_cnt      <= next_idle;
      cts_n_out     <= next_cts_n;
    end
  end

  // transmit side: rf ingest with whole-packet fit check, uart output
  always_comb begin
    // room is checked once, so a wrong length may lose trailing bytes
    fits = (FW'(rf_rx_len_in) + (framed_mode_in ?
            FW'(sbp_pkg::SRC_HDR_BYTES) : FW'(0))) <=
           FW'(tx_free_out);
    next_ist = ist;
    tx_wr    = 1'b0;
    tx_wdata = rf_rx_data_in;
    unique case (ist)
      sbp_pkg::I_IDLE: begin
        if (rf_rx_valid_in) begin
          if (rf_rx_first_in && fits) begin
            next_ist = framed_mode_in ? sbp_pkg::I_HDR_HI
                                      : sbp_pkg::I_PASS;
          end else begin
            next_ist = sbp_pkg::I_DROP;
          end
        end else if (evt_valid_in && evt_ready_out) begin
          tx_wr    = tx_in_ready;
          tx_wdata = evt_data_in;
        end
      end
      sbp_pkg::I_HDR_HI: begin
        tx_wr    = tx_in_ready;
        tx_wdata = rf_rx_src_in[15:8];
        if (tx_in_ready) next_ist = sbp_pkg::I_HDR_LO;
      end
      sbp_pkg::I_HDR_LO: begin
        tx_wr    = tx_in_ready;
        tx_wdata = rf_rx_src_in[7:0];
        if (tx_in_ready) next_ist = sbp_pkg::I_PASS;
      end
      sbp_pkg::I_PASS: begin
        tx_wr = rf_rx_valid_in & rf_rx_ready_out & tx_in_ready;
        if (rf_rx_valid_in && rf_rx_ready_out && rf_rx_last_in) begin
          next_ist = sbp_pkg::I_IDLE;
        end
      end
      sbp_pkg::I_DROP: begin
        if (rf_rx_valid_in && rf_rx_ready_out && rf_rx_last_in) begin
          next_ist = sbp_pkg::I_IDLE;
        end
      end
      default: next_ist = sbp_pkg::I_IDLE;
    endcase
    next_rf_ready  = (next_ist == sbp_pkg::I_PASS) |
                     (next_ist == sbp_pkg::I_DROP);
    // margin of two covers the write that may land while this registers
    next_evt_ready = (next_ist == sbp_pkg::I_IDLE) & framed_mode_in &
                     ~rf_rx_valid_in & (tx_free_out > TXW'(2));
    // host raising rts stops the next byte; the one on the wire still ends
    rts_hold       = rts_flow_enable_setting_in & rts_n_in;
    tx_pop         = tx_out_valid & ~rts_hold &
                     (~ser_tx_valid_out | ser_tx_ready_in);
    next_tx_valid  = tx_pop | (ser_tx_valid_out & ~ser_tx_ready_in);
    next_tx_data   = tx_pop ? tx_out : ser_tx_data_out;
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ist              <= sbp_pkg::I_IDLE;
      rf_rx_ready_out  <= 1'b0;
      evt_ready_out    <= 1'b0;
      ser_tx_valid_out <= 1'b0;
      ser_tx_data_out  <= 8'h00;
    end else begin
      ist              <= next_ist;
      rf_rx_ready_out  <= next_rf_ready;
      evt_ready_out    <= next_evt_ready;
      ser_tx_valid_out <= next_tx_valid;
      ser_tx_data_out  <= next_tx_data;
    end
  end

  // characters handed to the host while rts holds output back
  logic [2:0] slip_cnt;
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) slip_cnt <= 3'h0;
    else if (!rts_hold) slip_cnt <= 3'h0;
    else if (ser_tx_valid_out && ser_tx_ready_in && slip_cnt != 3'h7)
      slip_cnt <= slip_cnt + 3'h1;
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  property p_rx_store;
    rx_wr |=> rx_free_out < RXW'(RX_DEPTH) || pkt_valid_out;
  endproperty
  a_rx_store: assert property (p_rx_store)
    else $error("accepted byte not held");
  property p_rf_busy;
    rf_rx_busy_in && !pkt_valid_out |=> !pkt_valid_out;
  endproperty
  a_rf_busy: assert property (p_rf_busy)
    else $error("forwarded during rf reception");
  property p_drop;
    ist == sbp_pkg::I_IDLE && rf_rx_valid_in && rf_rx_first_in && !fits
      |=> ist == sbp_pkg::I_DROP ##0 !tx_wr;
  endproperty
  a_drop: assert property (p_drop)
    else $error("oversize rf packet not dropped");
  property p_cts_off;
    cts_flow_enable_setting_in && rx_free_out <= RXW'(17) |=> cts_n_out;
  endproperty
  a_cts_off: assert property (p_cts_off)
    else $error("cts not deasserted at 17 free");
  property p_cts_on;
    cts_flow_enable_setting_in && rx_free_out >= RXW'(34) |=> !cts_n_out;
  endproperty
  a_cts_on: assert property (p_cts_on)
    else $error("cts not reasserted at 34 free");
  property p_rts;
    rts_flow_enable_setting_in && rts_n_in && !ser_tx_valid_out
      |=> !ser_tx_valid_out;
  endproperty
  a_rts: assert property (p_rts)
    else $error("byte started while rts high");
  property p_slip;
    slip_cnt <= 3'(sbp_pkg::RTS_SLIP_MAX);
  endproperty
  a_slip: assert property (p_slip)
    else $error("too many characters after rts");
  property p_to_zero;
    pst == sbp_pkg::P_IDLE && packetization_timeout_in == 8'h00 &&
      !framed_mode_in && !command_mode_in && !rf_rx_busy_in &&
      rx_used != '0 |=> pst == sbp_pkg::P_SEND;
  endproperty
  a_to_zero: assert property (p_to_zero)
    else $error("zero timeout did not release");
  property p_size;
    pst == sbp_pkg::P_IDLE && !framed_mode_in && !command_mode_in &&
      !rf_rx_busy_in && rx_used >= RXW'(PKT_MAX)
      |=> pst == sbp_pkg::P_SEND && rel_left == RXW'(PKT_MAX);
  endproperty
  a_size: assert property (p_size)
    else $error("full payload not released");
  property p_hdr;
    ist == sbp_pkg::I_HDR_HI && tx_in_ready
      |-> tx_wr && tx_wdata == rf_rx_src_in[15:8] ##1 ist == sbp_pkg::I_HDR_LO;
  endproperty
  a_hdr: assert property (p_hdr)
    else $error("source address not inserted");
endmodule

`default_nettype wire

// >>> rtl/sbp_pkg.sv
// shared constants and types for the serial buffer and packetizer block
package sbp_pkg;
  // flow-control thresholds, in bytes of free receive-buffer space
  localparam int CTS_OFF_FREE   = 17;
  localparam int CTS_ON_FREE    = 34;
  // most characters that may still leave after the host raises rts
  localparam int RTS_SLIP_MAX   = 5;
  // source address bytes put ahead of each rf payload in framed mode
  localparam int SRC_HDR_BYTES  = 2;
  // default buffer sizes and packet payload limit
  localparam int RX_DEPTH_DEF   = 64;
  localparam int TX_DEPTH_DEF   = 16;
  localparam int PKT_MAX_DEF    = 32;
  localparam int FIFO_DEPTH_DEF = 16;
  // width of the rf fit comparison
  localparam int FIT_W          = 9;
  // reset values
  localparam logic CTS_N_RST    = 1'b0;
  localparam logic [7:0] IDLE_RST = 8'h00;

  // one buffered byte; last marks a frame end in framed mode
  typedef struct packed {
    logic       last;
    logic [7:0] data;
  } sbp_byte_s;

  // receive-buffer release sequencer
  typedef enum logic [1:0] {
    P_IDLE  = 2'b00,
    P_SEND  = 2'b01,
    P_FRAME = 2'b11
  } sbp_pk_e;

  // rf payload ingest into the transmit buffer
  typedef enum logic [2:0] {
    I_IDLE   = 3'b000,
    I_HDR_HI = 3'b001,
    I_HDR_LO = 3'b011,
    I_PASS   = 3'b010,
    I_DROP   = 3'b110
  } sbp_in_e;
endpackage

// >>> dv/sbp_host_model.sv
// host microcontroller uart model: sends serial bytes, collects output bytes
`timescale 1ns/100ps
`default_nettype none
module sbp_host_model (
  input  wire logic       clk_in,          // system clock
  input  wire logic       slow_in,         // 1 = accept every other cycle
  input  wire logic       ser_tx_valid_in, // byte from device
  input  wire logic [7:0] ser_tx_data_in,  // byte value
  output logic            ser_tx_ready_out,// host takes byte
  input  wire logic       ser_rx_ready_in, // device has room
  output logic            ser_rx_valid_out,// byte to device
  output logic [7:0]      ser_rx_data_out, // byte value
  output logic            ser_rx_last_out  // frame end
);
  logic [7:0] rxq[$];
  initial begin
    ser_tx_ready_out = 1'b0;
    ser_rx_valid_out = 1'b0;
    ser_rx_data_out  = 8'h00;
    ser_rx_last_out  = 1'b0;
  end
  // host stays able to take bytes even after raising rts
  always @(posedge clk_in) begin
    if (ser_tx_valid_in && ser_tx_ready_out)
      rxq.push_back(ser_tx_data_in);
    ser_tx_ready_out <= slow_in ? ~ser_tx_ready_out : 1'b1;
  end
  // in framed mode the last byte of a frame is flagged
  task automatic send(input int n, input logic [7:0] base, input logic lst);
    int k;
    for (int i = 0; i < n; i++) begin
      @(negedge clk_in);
      ser_rx_valid_out = 1'b1;
      ser_rx_data_out  = base + i[7:0];
      ser_rx_last_out  = lst && (i == n - 1);
      k = 0;
      while (!ser_rx_ready_in && k < 200) begin
        @(negedge clk_in);
        k++;
      end
    end
    @(negedge clk_in);
    ser_rx_valid_out = 1'b0;
    // released line shows garbage, not the last byte
    ser_rx_data_out  = ~ser_rx_data_out;
    ser_rx_last_out  = 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> dv/test_sbp_serial_buffer.sv
// self-checking bench for the serial buffer and packetizer block
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fails++; \
  $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module test_sbp_serial_buffer;
  localparam int RXD = 64;
  localparam int TXD = 16;
  logic clk_in = 1'b0, resetn_in = 1'b0, rts_en = 1'b0, cts_en = 1'b0;
  logic framed = 1'b0, cmd_mode = 1'b0, tick = 1'b0, seq = 1'b0;
  logic busy = 1'b0, pkt_rdy = 1'b0, rf_v = 1'b0, rf_first = 1'b0;
  logic rf_last = 1'b0, evt_v = 1'b0, rts_n = 1'b0, slow = 1'b0;
  logic [7:0] timeout = 8'h00, rf_d = 8'h00, rf_len = 8'h00, evt_d = 8'h00;
  logic [15:0] rf_src = 16'h0000;
  logic rx_v, rx_last, rx_rdy, cts_n, pkt_v, pkt_last, rf_rdy, evt_rdy;
  logic tx_v, tx_rdy;
  logic [7:0] rx_d, pkt_d, tx_d;
  logic [6:0] rx_free;
  logic [4:0] tx_free;
  int fails = 0, samples_checked = 0, cyc = 0;

  sbp_serial_buffer #(.RX_DEPTH(RXD), .TX_DEPTH(TXD), .PKT_MAX(32)) u_dut (
    .clk_in(clk_in), .resetn_in(resetn_in),
    .rts_flow_enable_setting_in(rts_en), .cts_flow_enable_setting_in(cts_en),
    .framed_mode_in(framed), .command_mode_in(cmd_mode),
    .packetization_timeout_in(timeout), .char_tick_in(tick),
    .cmd_seq_detect_in(seq), .ser_rx_valid_in(rx_v), .ser_rx_data_in(rx_d),
    .ser_rx_last_in(rx_last), .ser_rx_ready_out(rx_rdy), .cts_n_out(cts_n),
    .rx_free_out(rx_free), .rf_rx_busy_in(busy), .pkt_valid_out(pkt_v),
    .pkt_data_out(pkt_d), .pkt_last_out(pkt_last), .pkt_ready_in(pkt_rdy),
    .rf_rx_valid_in(rf_v), .rf_rx_data_in(rf_d), .rf_rx_first_in(rf_first),
    .rf_rx_last_in(rf_last), .rf_rx_len_in(rf_len), .rf_rx_src_in(rf_src),
    .rf_rx_ready_out(rf_rdy), .evt_valid_in(evt_v), .evt_data_in(evt_d),
    .evt_ready_out(evt_rdy), .ser_tx_valid_out(tx_v),
    .ser_tx_data_out(tx_d), .ser_tx_ready_in(tx_rdy), .rts_n_in(rts_n),
    .tx_free_out(tx_free));

  sbp_host_model u_host (
    .clk_in(clk_in), .slow_in(slow), .ser_tx_valid_in(tx_v),
    .ser_tx_data_in(tx_d), .ser_tx_ready_out(tx_rdy),
    .ser_rx_ready_in(rx_rdy), .ser_rx_valid_out(rx_v),
    .ser_rx_data_out(rx_d), .ser_rx_last_out(rx_last));

  always #10 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic get_pkt(input int n, input logic [7:0] base);
    int k;
    @(negedge clk_in);
    pkt_rdy = 1'b1;
    for (int i = 0; i < n; i++) begin
      k = 0;
      while (!pkt_v && k < 100) begin
        @(negedge clk_in);
        k++;
      end
      `CHK(pkt_v, 1'b1)
      `CHK(pkt_d, base + i[7:0])
      `CHK(pkt_last, i == n - 1)
      @(negedge clk_in);
    end
    pkt_rdy = 1'b0;
  endtask

  task automatic rf_send(input int n, input logic [7:0] base,
                         input logic [15:0] src);
    int k;
    for (int i = 0; i < n; i++) begin
      @(negedge clk_in);
      rf_v = 1'b1;
      rf_d = base + i[7:0];
      rf_first = (i == 0);
      rf_last = (i == n - 1);
      rf_len = n[7:0];
      rf_src = src;
      k = 0;
      while (!rf_rdy && k < 100) begin
        @(negedge clk_in);
        k++;
      end
    end
    @(negedge clk_in);
    rf_v = 1'b0;
    rf_d = ~rf_d;
    rf_first = 1'b0;
    rf_last = 1'b0;
  endtask

  task automatic host_wait(input int n);
    int k;
    k = 0;
    while (u_host.rxq.size() < n && k < 300) begin
      @(negedge clk_in);
      k++;
    end
  endtask

  task automatic host_chk(input int n, input logic [7:0] base);
    logic [7:0] b;
    host_wait(n);
    `CHK(u_host.rxq.size() >= n, 1'b1)
    for (int i = 0; i < n && u_host.rxq.size() > 0; i++) begin
      b = u_host.rxq.pop_front();
      `CHK(b, base + i[7:0])
    end
  endtask

  task automatic pulse_tick();
    @(negedge clk_in);
    tick = 1'b1;
    @(negedge clk_in);
    tick = 1'b0;
  endtask

  task automatic t_cts();
    cts_en = 1'b1;
    cmd_mode = 1'b1;
    u_host.send(47, 8'h00, 1'b0);
    @(negedge clk_in);
    `CHK(rx_free, 7'd17)
    `CHK(cts_n, 1'b1)
    seq = 1'b1;
    @(negedge clk_in);
    seq = 1'b0;
    get_pkt(32, 8'h00);
    `CHK(cts_n, 1'b0)
    // flush covers everything buffered, even beyond one packet
    get_pkt(15, 8'h20);
    cmd_mode = 1'b0;
    u_host.send(1, 8'h30, 1'b0);
    get_pkt(1, 8'h30);
    cts_en = 1'b0;
  endtask

  task automatic t_busy();
    busy = 1'b1;
    u_host.send(3, 8'h40, 1'b0);
    repeat (8) @(negedge clk_in);
    `CHK(pkt_v, 1'b0)
    busy = 1'b0;
    get_pkt(3, 8'h40);
  endtask

  task automatic t_timeout();
    timeout = 8'h03;
    u_host.send(2, 8'h50, 1'b0);
    repeat (2) pulse_tick();
    repeat (4) @(negedge clk_in);
    `CHK(pkt_v, 1'b0)
    pulse_tick();
    get_pkt(2, 8'h50);
    timeout = 8'hff;
    // no ticks now, so only the payload count can release
    u_host.send(32, 8'h80, 1'b0);
    get_pkt(32, 8'h80);
  endtask

  task automatic t_drop();
    int n0;
    rf_send(4, 8'h10, 16'h0000);
    host_chk(4, 8'h10);
    rts_en = 1'b1;
    rf_send(5, 8'h20, 16'h0000);
    rf_send(5, 8'h25, 16'h0000);
    rf_send(5, 8'h2a, 16'h0000);
    repeat (3) @(negedge clk_in);
    `CHK(tx_free, 5'd1)
    rf_send(5, 8'hf0, 16'h0000);
    repeat (3) @(negedge clk_in);
    `CHK(tx_free, 5'd1)
    `CHK(u_host.rxq.size() == 0, 1'b1)
    // slow host keeps a byte in flight when rts rises
    slow = 1'b1;
    rts_n = 1'b0;
    host_wait(3);
    rts_n = 1'b1;
    n0 = u_host.rxq.size();
    repeat (30) @(negedge clk_in);
    `CHK(u_host.rxq.size() - n0 <= 5, 1'b1)
    // host lets rts fall again soon so the buffer drains
    rts_n = 1'b0;
    host_chk(15, 8'h20);
    slow = 1'b0;
    rts_en = 1'b0;
  endtask

  task automatic t_framed();
    logic [7:0] b;
    framed = 1'b1;
    timeout = 8'h00;
    rf_send(2, 8'h60, 16'h1234);
    host_wait(4);
    b = u_host.rxq.pop_front();
    `CHK(b, 8'h12)
    b = u_host.rxq.pop_front();
    `CHK(b, 8'h34)
    host_chk(2, 8'h60);
    @(negedge clk_in);
    evt_v = 1'b1;
    evt_d = 8'h7e;
    repeat (50) if (!evt_rdy) @(negedge clk_in);
    @(negedge clk_in);
    evt_v = 1'b0;
    evt_d = 8'h81;
    host_chk(1, 8'h7e);
    u_host.send(3, 8'h90, 1'b1);
    get_pkt(3, 8'h90);
    framed = 1'b0;
  endtask

  initial begin
    rts_n = 1'b1;
    repeat (5) @(negedge clk_in);
    `CHK(rx_free, 7'(RXD))
    `CHK(tx_free, 5'(TXD))
    `CHK(cts_n, 1'b0)
    `CHK(rx_rdy, 1'b1)
    resetn_in = 1'b1;
    t_cts();
    t_busy();
    t_timeout();
    t_drop();
    t_framed();
    summarize();
  end
endmodule
`default_nettype wire
